// >>> logic/fvs_core.v
// Frequency command selection, limiting and V/F curve settings.
//
// Contract
// RQ1: Boost is zero-hertz voltage, 0-30%, default 6%.
// RQ2: Second-set input selects second boost; 9999 invalid.
// RQ3: Boost ignored in flux vector mode.
// RQ4: Factory boost rewritten when constant-torque motor chosen.
// RQ5: Command above maximum clamps to maximum, 0-120 Hz.
// RQ6: Minimum frequency is lower limit, default 0 Hz.
// RQ7: High-speed maximum 120-400 Hz, mirrors maximum both ways.
// RQ8: Minimum above start frequency runs on start alone.
// RQ9: Base frequency 0-400 Hz, default 60, curve breakpoint.
// RQ10: Base voltage 0-1000 V, 8888 and 9999 codes.
// RQ11: Second-set input selects second base frequency; 9999 invalid.
// RQ12: Flux mode drops base settings, keeps S-curve inflection.
// RQ13: One second-set input switches all second functions.
// RQ14: Four select inputs choose a preset speed.
// RQ15: High, mid, low presets 0-400 Hz, default 60/30/10.
// RQ16: Presets four to fifteen accept 9999, not selected.
// RQ17: Three-speed use gives lower-speed input priority.
// RQ18: Presets four to fifteen have no priority.
// RQ19: Preset writes accepted while running.
// RQ20: Presets work in network and panel modes.
// RQ21: Configurer keeps boost near ten percent or below.
// RQ22: Second-set input selects second acceleration and deceleration.
// RQ23: Binary code maps inputs; all off selects none.
// RQ24: Limits applied after choosing preset or external command.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "fvs_defines.vh"

module fvs_core #(
  parameter AW = 8,
  parameter DW = 16
) (
  input  wire          core_clk,
  input  wire          rst_n,
  input  wire [AW-1:0] reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  input  wire          second_set_select,
  input  wire          speed_select_high,
  input  wire          speed_select_mid,
  input  wire          speed_select_low,
  input  wire          speed_select_ext,
  input  wire          start_cmd,
  input  wire [DW-1:0] ext_freq_cmd,
  output reg  [DW-1:0] out_freq,
  output reg  [DW-1:0] boost_out,
  output reg  [DW-1:0] base_freq_out,
  output reg  [DW-1:0] base_volt_out,
  output reg  [DW-1:0] inflect_freq_out,
  output reg  [DW-1:0] acc_time_out,
  output reg  [DW-1:0] dec_time_out,
  output reg           vf_bypass_out,
  output reg           second_active_out
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function in_range;
    input [DW-1:0] v;
    input [DW-1:0] lo;
    input [DW-1:0] hi;
    begin
      in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  function [DW-1:0] pick_second;
    input          sel;
    input [DW-1:0] first;
    input [DW-1:0] second;
    begin
      pick_second = (sel && second != `FVS_CODE_OFF) ? second : first;
    end
  endfunction

  function is_preset;
    input [AW-1:0] a;
    begin
      is_preset = ((a >> 6) == (`FVS_A_PRESET >> 6));
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg  [5:0] pin_s1_r;
  reg  [5:0] pin_s2_r;
  wire [5:0] pin_raw = {start_cmd, second_set_select, speed_select_ext,
                        speed_select_high, speed_select_mid, speed_select_low};
  wire       sel_low  = pin_s2_r[0];
  wire       sel_mid  = pin_s2_r[1];
  wire       sel_high = pin_s2_r[2];
  wire       sel_ext  = pin_s2_r[3];
  wire       sel_2nd  = pin_s2_r[4];
  wire       start_s  = pin_s2_r[5];

  always @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  // --------------------------------------------------------------------------
  // Setting registers
  // --------------------------------------------------------------------------
  reg [DW-1:0] boost_r;
  reg [DW-1:0] boost2_r;
  reg [DW-1:0] max_r;
  reg [DW-1:0] hs_max_r;
  reg [DW-1:0] min_r;
  reg [DW-1:0] base_r;
  reg [DW-1:0] base2_r;
  reg [DW-1:0] volt_r;
  reg [DW-1:0] acc_r;
  reg [DW-1:0] dec_r;
  reg [DW-1:0] acc2_r;
  reg [DW-1:0] dec2_r;
  reg [DW-1:0] start_f_r;
  reg [3:0]    ctrl_r;
  reg [DW-1:0] preset_r [0:`FVS_PRESET_SLOTS-1];

  wire [DW-1:0] wv       = reg_wdata[DW-1:0];
  wire          wr_pre   = reg_wr && is_preset(reg_addr);
  wire [3:0]    wr_slot  = reg_addr[5:2];
  wire          ct_rise  = reg_wr && (reg_addr == `FVS_A_CTRL) &&
                           reg_wdata[`FVS_CTRL_CTMOTOR] && !ctrl_r[`FVS_CTRL_CTMOTOR];
  wire          is_3slot = (wr_slot == `FVS_SLOT_LOW) || (wr_slot == `FVS_SLOT_MID) ||
                           (wr_slot == `FVS_SLOT_HIGH);
  integer i;

  // Out-of-range writes are dropped so the previous setting stays in force.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      boost_r   <= `FVS_BOOST_RST;
      boost2_r  <= `FVS_CODE_OFF;
      max_r     <= `FVS_MAX_RST;
      hs_max_r  <= `FVS_MAX_RST;
      min_r     <= `FVS_MIN_RST;
      base_r    <= `FVS_BASE_RST;
      base2_r   <= `FVS_CODE_OFF;
      volt_r    <= `FVS_CODE_OFF;
      acc_r     <= `FVS_ACC_RST;
      dec_r     <= `FVS_ACC_RST;
      acc2_r    <= `FVS_ACC_RST;
      dec2_r    <= `FVS_CODE_OFF;
      start_f_r <= `FVS_START_RST;
      ctrl_r    <= 4'h0;
      for (i = 0; i < `FVS_PRESET_SLOTS; i = i + 1) begin
        preset_r[i] <= `FVS_CODE_OFF; // RQ16
      end
      preset_r[`FVS_SLOT_HIGH] <= `FVS_HIGH_RST; // RQ15
      preset_r[`FVS_SLOT_MID]  <= `FVS_MID_RST; // RQ15
      preset_r[`FVS_SLOT_LOW]  <= `FVS_LOW_RST; // RQ15
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `FVS_A_BOOST: begin
            if (wv <= `FVS_BOOST_MAX) begin
              boost_r <= wv; // RQ1
            end
          end
          `FVS_A_BOOST2: begin
            if (wv <= `FVS_BOOST_MAX || wv == `FVS_CODE_OFF) begin
              boost2_r <= wv; // RQ2
            end
          end
          `FVS_A_MAX_FREQ: begin
            if (wv <= `FVS_FMAX_LIM) begin
              max_r    <= wv; // RQ5
              hs_max_r <= wv; // RQ7
            end
          end
          `FVS_A_HS_MAX: begin
            if (in_range(wv, `FVS_FMAX_LIM, `FVS_FTOP_LIM)) begin
              hs_max_r <= wv; // RQ7
              max_r    <= wv; // RQ7
            end
          end
          `FVS_A_MIN_FREQ: begin
            if (wv <= `FVS_FMAX_LIM) begin
              min_r <= wv; // RQ6
            end
          end
          `FVS_A_BASE_FREQ: begin
            if (wv <= `FVS_FTOP_LIM) begin
              base_r <= wv; // RQ9
            end
          end
          `FVS_A_BASE_FREQ2: begin
            if (wv <= `FVS_FTOP_LIM || wv == `FVS_CODE_OFF) begin
              base2_r <= wv; // RQ11
            end
          end
          `FVS_A_BASE_VOLT: begin
            if (wv <= `FVS_VOLT_LIM || wv == `FVS_CODE_95PCT || wv == `FVS_CODE_OFF) begin
              volt_r <= wv; // RQ10
            end
          end
          `FVS_A_ACC:        acc_r     <= wv;
          `FVS_A_DEC:        dec_r     <= wv;
          `FVS_A_ACC2:       acc2_r    <= wv;
          `FVS_A_DEC2:       dec2_r    <= wv;
          `FVS_A_START_FREQ: start_f_r <= wv;
          `FVS_A_CTRL:       ctrl_r    <= reg_wdata[3:0];
          default: begin
          end
        endcase
      end
      // Preset writes are honoured at any time, running or not, in either mode.
      if (wr_pre && wr_slot != 4'h0) begin // RQ19 RQ20
        if (wv <= `FVS_FTOP_LIM || (!is_3slot && wv == `FVS_CODE_OFF)) begin // RQ15 RQ16
          preset_r[wr_slot] <= wv;
        end
      end
      // Only a factory boost is replaced, so a user tuned value is never lost.
      if (ct_rise && boost_r == `FVS_BOOST_RST &&
          !(reg_wr && reg_addr == `FVS_A_BOOST)) begin // RQ4
        boost_r <= `FVS_BOOST_CT;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Preset selection and limiting
  // --------------------------------------------------------------------------
  reg  [3:0]    slot_nxt;
  reg  [DW-1:0] cmd_nxt;
  reg  [DW-1:0] freq_nxt;
  wire [3:0]    code = {sel_ext, sel_high, sel_mid, sel_low}; // RQ14 RQ23
  wire          flux = ctrl_r[`FVS_CTRL_FLUX];

  always @* begin
    slot_nxt = code; // RQ18 RQ23
    if (ctrl_r[`FVS_CTRL_3SPEED] && !sel_ext) begin
      if (sel_low) begin // RQ17
        slot_nxt = `FVS_SLOT_LOW;
      end else if (sel_mid) begin
        slot_nxt = `FVS_SLOT_MID;
      end else if (sel_high) begin
        slot_nxt = `FVS_SLOT_HIGH;
      end else begin
        slot_nxt = 4'h0;
      end
    end
    cmd_nxt = ext_freq_cmd;
    if (slot_nxt != 4'h0 && preset_r[slot_nxt] != `FVS_CODE_OFF) begin // RQ14 RQ16
      cmd_nxt = preset_r[slot_nxt];
    end
    // Clamps act on the chosen command, never on the stored presets.
    freq_nxt = cmd_nxt; // RQ24
    if (freq_nxt > max_r) begin // RQ5
      freq_nxt = max_r;
    end
    if (freq_nxt < min_r && min_r > start_f_r) begin // RQ6 RQ8
      freq_nxt = min_r;
    end
    if (!start_s) begin
      freq_nxt = {DW{1'b0}};
    end
  end

  // --------------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------------
  wire [DW-1:0] base_sel  = pick_second(sel_2nd, base_r, base2_r); // RQ11 RQ13
  wire [DW-1:0] boost_sel = pick_second(sel_2nd, boost_r, boost2_r); // RQ2 RQ13

  always @(posedge core_clk) begin
    if (!rst_n) begin
      out_freq          <= {DW{1'b0}};
      boost_out         <= {DW{1'b0}};
      base_freq_out     <= `FVS_BASE_RST;
      base_volt_out     <= `FVS_CODE_OFF;
      inflect_freq_out  <= `FVS_BASE_RST;
      acc_time_out      <= `FVS_ACC_RST;
      dec_time_out      <= `FVS_ACC_RST;
      vf_bypass_out     <= 1'b0;
      second_active_out <= 1'b0;
    end else begin
      out_freq          <= freq_nxt; // RQ24
      boost_out         <= flux ? {DW{1'b0}} : boost_sel; // RQ1 RQ2 RQ3
      base_freq_out     <= flux ? {DW{1'b0}} : base_sel; // RQ9 RQ12
      base_volt_out     <= flux ? {DW{1'b0}} : volt_r; // RQ10 RQ12
      inflect_freq_out  <= base_sel; // RQ12
      vf_bypass_out     <= flux; // RQ12
      second_active_out <= sel_2nd; // RQ13
      acc_time_out      <= sel_2nd ? acc2_r : acc_r; // RQ22
      // A second deceleration of 9999 follows the second acceleration time.
      dec_time_out      <= sel_2nd ? ((dec2_r == `FVS_CODE_OFF) ? acc2_r : dec2_r)
                                   : dec_r; // RQ22
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0000_0000;
    if (is_preset(reg_addr)) begin
      rd_nxt = {16'h0000, preset_r[reg_addr[5:2]]};
    end else begin
      case (reg_addr)
        `FVS_A_BOOST:      rd_nxt = {16'h0000, boost_r};
        `FVS_A_BOOST2:     rd_nxt = {16'h0000, boost2_r};
        `FVS_A_MAX_FREQ:   rd_nxt = {16'h0000, max_r};
        `FVS_A_HS_MAX:     rd_nxt = {16'h0000, hs_max_r};
        `FVS_A_MIN_FREQ:   rd_nxt = {16'h0000, min_r};
        `FVS_A_BASE_FREQ:  rd_nxt = {16'h0000, base_r};
        `FVS_A_BASE_FREQ2: rd_nxt = {16'h0000, base2_r};
        `FVS_A_BASE_VOLT:  rd_nxt = {16'h0000, volt_r};
        `FVS_A_ACC:        rd_nxt = {16'h0000, acc_r};
        `FVS_A_DEC:        rd_nxt = {16'h0000, dec_r};
        `FVS_A_ACC2:       rd_nxt = {16'h0000, acc2_r};
        `FVS_A_DEC2:       rd_nxt = {16'h0000, dec2_r};
        `FVS_A_START_FREQ: rd_nxt = {16'h0000, start_f_r};
        `FVS_A_CTRL:       rd_nxt = {28'h0000000, ctrl_r};
        `FVS_A_OUT_FREQ:   rd_nxt = {16'h0000, out_freq};
        `FVS_A_IN_STAT:    rd_nxt = {26'h0, pin_s2_r};
        default:           rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_nxt : 32'h0000_0000;
    end
  end

endmodule

// >>> logic/fvs_defines.vh
// Offsets, field positions, reset values and codes for the frequency command and V/F setup block.
`ifndef FVS_DEFINES_VH
`define FVS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FVS_A_BOOST       8'h00
`define FVS_A_MAX_FREQ    8'h04
`define FVS_A_MIN_FREQ    8'h08
`define FVS_A_BASE_FREQ   8'h0c
`define FVS_A_BASE_VOLT   8'h10
`define FVS_A_HS_MAX      8'h14
`define FVS_A_BOOST2      8'h18
`define FVS_A_BASE_FREQ2  8'h1c
`define FVS_A_ACC         8'h20
`define FVS_A_DEC         8'h24
`define FVS_A_ACC2        8'h28
`define FVS_A_DEC2        8'h2c
`define FVS_A_START_FREQ  8'h30
`define FVS_A_CTRL        8'h34
`define FVS_A_OUT_FREQ    8'h38
`define FVS_A_IN_STAT     8'h3c
`define FVS_A_PRESET      8'h80
`define FVS_PRESET_SLOTS  16

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define FVS_CTRL_FLUX     0
`define FVS_CTRL_CTMOTOR  1
`define FVS_CTRL_PANEL    2
`define FVS_CTRL_3SPEED   3

// ----------------------------------------------------------------------------
// Units: frequency 0.1 Hz, boost 0.1 %, voltage 1 V, time 0.1 s
// ----------------------------------------------------------------------------
`define FVS_CODE_OFF      16'd9999
`define FVS_CODE_95PCT    16'd8888
`define FVS_BOOST_MAX     16'd300
`define FVS_BOOST_RST     16'd60
`define FVS_BOOST_CT      16'd40
`define FVS_FMAX_LIM      16'd1200
`define FVS_FTOP_LIM      16'd4000
`define FVS_VOLT_LIM      16'd1000
`define FVS_MAX_RST       16'd1200
`define FVS_MIN_RST       16'h0000
`define FVS_BASE_RST      16'd600
`define FVS_HIGH_RST      16'd600
`define FVS_MID_RST       16'd300
`define FVS_LOW_RST       16'd100
`define FVS_ACC_RST       16'd50
`define FVS_START_RST     16'd5
`define FVS_SLOT_LOW      4'h1
`define FVS_SLOT_MID      4'h2
`define FVS_SLOT_HIGH     4'h4

`endif

// >>> sim/fvs_core_properties.sv
// Port-level checker for the frequency command block, bound to its top module.
`timescale 1ns/1ps
`include "fvs_defines.vh"
module fvs_core_properties #(
  parameter AW = 8,
  parameter DW = 16
) (
  input wire          core_clk,
  input wire          rst_n,
  input wire [AW-1:0] reg_addr,
  input wire          reg_rd,
  input wire [31:0]   reg_rdata,
  input wire          start_cmd,
  input wire          second_set_select,
  input wire [DW-1:0] out_freq,
  input wire [DW-1:0] boost_out,
  input wire [DW-1:0] base_freq_out,
  input wire [DW-1:0] base_volt_out,
  input wire [DW-1:0] inflect_freq_out,
  input wire          vf_bypass_out,
  input wire          second_active_out
);
  // --------------------------------------------------------------------------
  // Relations
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_stop_zero: assert property ((!start_cmd)[*4] |=> out_freq == 0)
    else $error("output frequency not zero while stopped");
  chk_second_flag: assert property (second_set_select[*4] |=> second_active_out)
    else $error("second set not active");
  chk_flux_zero: assert property (vf_bypass_out |-> boost_out == 0 && base_volt_out == 0)
    else $error("boost or voltage used in flux mode");
  chk_flux_base: assert property (vf_bypass_out |-> base_freq_out == 0)
    else $error("base frequency used in flux mode");
  chk_inflect_same: assert property (!vf_bypass_out |-> inflect_freq_out == base_freq_out)
    else $error("inflection differs from base frequency");
  chk_out_read: assert property (reg_rd && reg_addr == `FVS_A_OUT_FREQ
    |=> reg_rdata == {16'h0000, $past(out_freq)})
    else $error("output frequency readback wrong");
  chk_slot_none: assert property (reg_rd && reg_addr == `FVS_A_PRESET
    |=> reg_rdata == 32'd9999)
    else $error("slot zero not unselected");
  chk_boost_range: assert property (boost_out <= `FVS_BOOST_MAX)
    else $error("boost out of range");
  chk_volt_codes: assert property (base_volt_out <= `FVS_VOLT_LIM
    || base_volt_out == `FVS_CODE_95PCT || base_volt_out == `FVS_CODE_OFF)
    else $error("base voltage out of range");
  chk_freq_top: assert property (out_freq <= `FVS_FTOP_LIM
    && base_freq_out <= `FVS_FTOP_LIM)
    else $error("frequency above top limit");
endmodule
bind fvs_core fvs_core_properties #(.AW(AW), .DW(DW)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .start_cmd(start_cmd), .second_set_select(second_set_select),
  .out_freq(out_freq), .boost_out(boost_out), .base_freq_out(base_freq_out),
  .base_volt_out(base_volt_out), .inflect_freq_out(inflect_freq_out),
  .vf_bypass_out(vf_bypass_out), .second_active_out(second_active_out));

// >>> sim/fvs_pin_model.sv
// Model of the master that drives the start and select pins.
`timescale 1ns/1ps
module fvs_pin_model (
  input  wire       core_clk,
  input  wire [5:0] pin_req,
  output reg        start_cmd,
  output reg        second_set_select,
  output reg        speed_select_ext,
  output reg        speed_select_high,
  output reg        speed_select_mid,
  output reg        speed_select_low
);
  // --------------------------------------------------------------------------
  // Pin levels
  // --------------------------------------------------------------------------
  // Levels move only just after an edge and then hold, so the synchroniser never sees a glitch.
  always @(posedge core_clk) begin
    {start_cmd, second_set_select, speed_select_ext} <= pin_req[5:3];
    {speed_select_high, speed_select_mid, speed_select_low} <= pin_req[2:0];
  end
endmodule

// >>> sim/tb_fvs_core.sv
// Self-checking testbench of the frequency command block.
`timescale 1ns/1ps
`include "fvs_defines.vh"
module tb_fvs_core;
  reg         core_clk;
  reg         rst_n;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg  [5:0]  pin_req;
  reg  [15:0] ext_freq_cmd;
  wire [31:0] reg_rdata;
  wire        start_cmd, second_set_select, speed_select_ext;
  wire        speed_select_high, speed_select_mid, speed_select_low;
  wire [15:0] out_freq, boost_out, base_freq_out, base_volt_out, inflect_freq_out;
  wire [15:0] acc_time_out, dec_time_out;
  wire        vf_bypass_out, second_active_out;
  reg  [15:0] slot [0:15];
  reg  [15:0] mx, mn, v;
  reg         three;
  reg  [31:0] seed;
  integer     errors, checked, cycles, i;
  // --------------------------------------------------------------------------
  // Structure
  // --------------------------------------------------------------------------
  fvs_pin_model i_pins (.core_clk(core_clk), .pin_req(pin_req), .start_cmd(start_cmd),
    .second_set_select(second_set_select), .speed_select_ext(speed_select_ext),
    .speed_select_high(speed_select_high), .speed_select_mid(speed_select_mid),
    .speed_select_low(speed_select_low));
  fvs_core #(.AW(8), .DW(16)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .second_set_select(second_set_select), .speed_select_high(speed_select_high),
    .speed_select_mid(speed_select_mid), .speed_select_low(speed_select_low),
    .speed_select_ext(speed_select_ext), .start_cmd(start_cmd), .ext_freq_cmd(ext_freq_cmd),
    .out_freq(out_freq), .boost_out(boost_out), .base_freq_out(base_freq_out),
    .base_volt_out(base_volt_out), .inflect_freq_out(inflect_freq_out),
    .acc_time_out(acc_time_out), .dec_time_out(dec_time_out),
    .vf_bypass_out(vf_bypass_out), .second_active_out(second_active_out));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [31:0] xs(input [31:0] x);
    begin
      xs = x ^ (x << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  function [15:0] exp_out(input [3:0] code, input [15:0] ext);
    reg [3:0] c;
    reg [15:0] f;
    begin
      c = code;
      if (three && !c[3]) c = c[0] ? 4'h1 : c[1] ? 4'h2 : c[2] ? 4'h4 : 4'h0;
      f = (slot[c] == `FVS_CODE_OFF) ? ext : slot[c];
      if (f > mx) f = mx;
      if (f < mn && mn > `FVS_START_RST) f = mn;
      exp_out = f;
    end
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= {16'h0000, d};
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask
  task pins(input [5:0] p);
    begin
      @(posedge core_clk);
      pin_req <= p;
      repeat (6) @(posedge core_clk);
      #1;
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    cycles = 0;
    seed = 32'h4b699a31;
    three = 1'b0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pin_req = 6'h00;
    ext_freq_cmd = 16'h0000;
    for (i = 0; i < 16; i = i + 1) slot[i] = `FVS_CODE_OFF;
    slot[1] = `FVS_LOW_RST;
    slot[2] = `FVS_MID_RST;
    slot[4] = `FVS_HIGH_RST;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(`FVS_A_BOOST, 32'd60);
    rdc(`FVS_A_MAX_FREQ, 32'd1200);
    rdc(`FVS_A_HS_MAX, 32'd1200);
    rdc(`FVS_A_MIN_FREQ, 32'd0);
    rdc(`FVS_A_BASE_VOLT, 32'd9999);
    rdc(`FVS_A_BOOST2, 32'd9999);
    rdc(`FVS_A_BASE_FREQ2, 32'd9999);
    rdc(8'h84, 32'd100);
    rdc(8'h8c, 32'd9999);
    rdc(8'h80, 32'd9999);
    rdc(8'h40, 32'd0);
    chk(base_freq_out, 32'd600);
    wr(`FVS_A_CTRL, 16'h0002);
    rdc(`FVS_A_BOOST, 32'd40);
    wr(`FVS_A_BOOST, 16'd301);
    rdc(`FVS_A_BOOST, 32'd40);
    wr(`FVS_A_BOOST, 16'd100);
    wr(`FVS_A_MAX_FREQ, 16'd500);
    rdc(`FVS_A_HS_MAX, 32'd500);
    wr(`FVS_A_HS_MAX, 16'd3000);
    rdc(`FVS_A_MAX_FREQ, 32'd3000);
    wr(`FVS_A_HS_MAX, 16'd1100);
    rdc(`FVS_A_HS_MAX, 32'd3000);
    wr(`FVS_A_MAX_FREQ, 16'd800);
    mx = 16'd800;
    wr(`FVS_A_BASE_VOLT, 16'd8888);
    wr(`FVS_A_BASE_VOLT, 16'd1001);
    rdc(`FVS_A_BASE_VOLT, 32'd8888);
    wr(`FVS_A_BOOST2, 16'd90);
    wr(`FVS_A_BASE_FREQ2, 16'd500);
    wr(`FVS_A_ACC2, 16'd70);
    pins(6'h10);
    chk({boost_out, base_freq_out}, {16'd90, 16'd500});
    chk({acc_time_out, dec_time_out}, {16'd70, 16'd70});
    chk(second_active_out, 32'd1);
    wr(`FVS_A_DEC2, 16'd80);
    repeat (2) @(posedge core_clk);
    #1;
    chk(dec_time_out, 32'd80);
    wr(`FVS_A_BOOST2, 16'd9999);
    wr(`FVS_A_CTRL, 16'h0001);
    pins(6'h00);
    chk(boost_out, 32'h0);
    chk({base_freq_out, base_volt_out}, 32'h0);
    chk({vf_bypass_out, inflect_freq_out}, {1'b1, 16'd600});
    wr(`FVS_A_CTRL, 16'h0000);
    wr(`FVS_A_MIN_FREQ, 16'd50);
    mn = 16'd50;
    pins(6'h20);
    chk(out_freq, 32'd50);
    chk(boost_out, 32'd100);
    for (i = 0; i < 64; i = i + 1) begin
      seed = xs(seed);
      three = i[4];
      wr(`FVS_A_CTRL, {12'h000, i[4], i[5], 2'b00});
      v = seed[27:16] % 16'd4001;
      if (seed[31] && (i[3:0] == 4'h3 || i[3:0] > 4'h4)) v = `FVS_CODE_OFF;
      if (i[3:0] != 4'h0) wr(`FVS_A_PRESET + {i[3:0], 2'b00}, v);
      if (i[3:0] != 4'h0) slot[i[3:0]] = v;
      ext_freq_cmd <= {5'h00, seed[10:0]};
      pins({2'b10, i[3:0]});
      chk(out_freq, exp_out(i[3:0], ext_freq_cmd));
    end
    rdc(`FVS_A_OUT_FREQ, {16'h0000, exp_out(4'hf, ext_freq_cmd)});
    report_and_stop;
  end
endmodule
